// ### src/meter_params.svh
// constants for the meter settings and event logic
`ifndef METER_PARAMS_SVH
`define METER_PARAMS_SVH

// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_DELAY       8'h04
`define REG_WEIGHT      8'h08
`define REG_FUNC        8'h0C
`define REG_STATUS      8'h10
`define REG_ERROR       8'h14
`define REG_POLL        8'h18
`define REG_READING     8'h1C

// control word fields
`define CTRL_FUNC_LSB   0
`define CTRL_DIG_LSB    4
`define CTRL_RANGE_LSB  8
`define CTRL_BUS_TRIG   12
`define CTRL_EXT_TRIG   13
`define CTRL_RQS        14
`define CTRL_FILT       15
`define CTRL_EN_LSB     16
`define CTRL_RST        32'h00200000

// class enable bits: overflow, full, half, user, completion, error
`define EN_W            6
`define EN_OVER         0
`define EN_FULL         1
`define EN_HALF         2
`define EN_USER         3
`define EN_DONE         4
`define EN_ERR          5

// event slots, lower slot is higher priority; code is slot plus one
`define EV_N            7
`define EV_PON          0
`define EV_SYNTAX       1
`define EV_OVER         2
`define EV_FULL         3
`define EV_HALF         4
`define EV_USER         5
`define EV_DONE         6
`define STB_RQS_BIT     6

// status word fields
`define STAT_PEND_LSB   0
`define STAT_QV         8
`define STAT_SRQ        9
`define STAT_BUSY       10
`define STAT_DISP_LSB   12
`define STAT_SENT_LSB   16
`define SENT_DIGITS     4'h7

// digits and filter weights
`define DIG_MIN         3'h3
`define DIG_MAX         3'h6
`define DIG_CAP         3'h5
`define OHM_HI_RANGE    3'h5
`define WEIGHT_MIN      7'h01
`define WEIGHT_MAX      7'h63
`define WEIGHT_RST      7'h01

// timing
`define CLK_PERIOD_NS   100
`define MS_NS           1000000
`define CYC_W           16
`define DELAY_W         16
`define DATA_W          24

`endif

// ### src/meter_pkg.sv
// types shared by the meter settings and event logic
package meter_pkg;
`include "meter_params.svh"

   typedef enum logic [2:0] {dc_volts, ac_volts, resistance, dc_current, ac_current,
                             ac_volts_decibel, ac_current_decibel, compensated_resistance} func_t;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_CONV} seq_t;

   typedef struct packed {
      logic syntax_err;
      logic user_evt;
      logic buf_full;
      logic buf_half;
      logic buf_circular;
   } evt_t;

   typedef struct packed {
      logic               valid;
      logic               ovf;
      logic [`DATA_W-1:0] data;
   } conv_t;

   typedef struct packed {
      func_t                    func;
      logic [2:0]               dig_req;
      logic [2:0]               range_sel;
      logic                     bus_trig_en;
      logic                     ext_trig_en;
      logic                     rqs_en;
      logic                     filt_en;
      logic [`EN_W-1:0]         class_en;
      logic [`DELAY_W-1:0]      delay_ms;
      logic [7:0][6:0]          weight;
      seq_t                     seq;
      logic [`DELAY_W-1:0]      ms_left;
      logic [`CYC_W-1:0]        cyc;
      logic                     conv_start;
      logic [`DATA_W-1:0]       avg;
      logic                     avg_valid;
      logic [`EV_N-1:0]         pend;
      logic [2:0]               first_idx;
      logic                     first_v;
      logic [7:0]               queued;
      logic                     queued_v;
      logic                     pon_todo;
      logic                     srq;
      logic [31:0]              rdata;
      logic [2:0]               disp;
      logic                     ext_prev;
   } state_t;
endpackage

// ### src/sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         dout   <= '0;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### src/digit_map.sv
// displayed digit count from request, function and range
`timescale 1ns/1ps
`default_nettype none
`include "meter_params.svh"
module digit_map import meter_pkg::*; (
   // setting
   input  wire func_t      func,
   input  wire logic [2:0] range_sel,
   input  wire logic [2:0] req,
   // result
   output logic      [2:0] shown
);
   always_comb
   begin
      case (func)
         ac_volts, dc_current, ac_current:
            shown = (req > `DIG_CAP) ? `DIG_CAP : req;
         ac_volts_decibel, ac_current_decibel:
            shown = `DIG_CAP;
         resistance:
            shown = (range_sel >= `OHM_HI_RANGE) ? `DIG_CAP : req;
         compensated_resistance:
            shown = (req == `DIG_MAX) ? `DIG_MAX : `DIG_CAP;
         default:
            shown = req;
      endcase
   end
endmodule
`default_nettype wire

// ### src/meter_ctrl.sv
// settings, trigger delay, filter and error/event queue of the meter
//
// Summary of operation
// - wait programmed milliseconds after trigger, then convert
// - displayed digits follow request, capped per function; dB functions, ohm ranges 5 up and compensated ohms below 6 show 5 always
// - digit query returns request; display recomputed
// - bus reading carries seven digits, raw value
// - bus trigger ORed with selected trigger source
// - with service request, errors wait for poll
// - each error code delivered once, matching poll
// - earliest error first, then highest priority
// - second poll discards the queued code
// - no service request: earliest first, then highest priority, newest kept
// - service request enable only gates the line
// - re-enabling a class drops its pending events
// - error reporting off drops syntax errors silently
// - power-on event waits for error reporting
// - one filter enable for all functions
// - per-function filter weight, 1 to 99
// - average plus difference divided by weight
// - full buffer raises service request, awaits poll
// - circular wrap gives no full event
// - no service request: full event queued by priority
// - eight functions, each also a standalone command
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "meter_params.svh"
module meter_ctrl import meter_pkg::*; #(
   parameter int CYCLES_PER_MS = `MS_NS / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // register port
   input  wire logic [7:0]   addr,
   input  wire logic [31:0]  wdata,
   input  wire logic         wr,
   input  wire logic         rd,
   output logic      [31:0]  rdata,
   // triggers
   input  wire logic         get_msg,
   input  wire logic         ext_trig,
   // converter
   output logic              conv_start,
   input  wire conv_t        conv,
   // events from buffer and parser
   input  wire evt_t         evt,
   // status to the bus interface and display
   output logic              srq,
   output logic      [2:0]   disp_digits
);
   localparam logic [`CYC_W-1:0] CYC_LAST = `CYC_W'(CYCLES_PER_MS - 1);

   if (CYCLES_PER_MS < 1 || CYCLES_PER_MS >= (1 << `CYC_W))
   begin : g_bad_rate
      $error("CYCLES_PER_MS out of range");
   end

   state_t                   s_q;
   state_t                   s_d;
   logic                     ext_s;
   logic [2:0]               shown;
   logic                     trig;
   logic [`EV_N-1:0]         ev;
   logic [`EV_N-1:0]         clr;
   logic [`EV_N-1:0]         left;
   logic [2:0]               sel;
   logic [`EN_W-1:0]         new_en;
   logic [2:0]               dig_w;
   logic [6:0]               w_cur;
   logic signed [`DATA_W:0]  diff;
   logic signed [`DATA_W:0]  step;
   int                       i;

   sync2 #(.W(1)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (ext_trig),
      .dout  (ext_s)
   );

   digit_map u_digits (
      .func      (s_q.func),
      .range_sel (s_q.range_sel),
      .req       (s_q.dig_req),
      .shown     (shown)
   );

   // weight of the function selected right now
   assign w_cur = s_q.weight[s_q.func];
   assign diff  = $signed({conv.data[`DATA_W-1], conv.data}) - $signed({s_q.avg[`DATA_W-1], s_q.avg});
   assign step  = diff / $signed({{(`DATA_W-6){1'b0}}, w_cur});
   assign trig  = (s_q.bus_trig_en & get_msg) | (s_q.ext_trig_en & ext_s & ~s_q.ext_prev);
   assign new_en = wdata[`CTRL_EN_LSB +: `EN_W];
   assign dig_w  = (wdata[`CTRL_DIG_LSB +: 3] < `DIG_MIN) ? `DIG_MIN :
                   (wdata[`CTRL_DIG_LSB +: 3] > `DIG_MAX) ? `DIG_MAX : wdata[`CTRL_DIG_LSB +: 3];

   // class enable bit that governs an event slot
   function automatic int en_of(input int slot);
      if (slot == `EV_SYNTAX)
         return `EN_ERR;
      return slot - 2;
   endfunction

   // earliest pending first, else lowest slot
   always_comb
   begin
      sel = s_q.first_idx;
      if (!s_q.first_v)
      begin
         sel = 3'h0;
         for (int k = `EV_N - 1; k >= 0; k--)
            if (s_q.pend[k])
               sel = 3'(k);
      end
   end

   always_comb
   begin
      s_d            = s_q;
      s_d.conv_start = 1'b0;
      s_d.rdata      = '0;
      s_d.ext_prev   = ext_s;
      ev             = '0;
      clr            = '0;
      left           = '0;

      // register writes
      if (wr)
      begin
         case (addr)
            `REG_CTRL:
            begin
               s_d.func        = func_t'(wdata[`CTRL_FUNC_LSB +: 3]);
               s_d.dig_req     = dig_w;
               s_d.range_sel   = wdata[`CTRL_RANGE_LSB +: 3];
               s_d.bus_trig_en = wdata[`CTRL_BUS_TRIG];
               s_d.ext_trig_en = wdata[`CTRL_EXT_TRIG];
               s_d.rqs_en      = wdata[`CTRL_RQS];
               s_d.filt_en     = wdata[`CTRL_FILT];
               s_d.class_en    = new_en;
               for (i = 1; i < `EV_N; i++)
                  if (!s_q.class_en[en_of(i)] && new_en[en_of(i)])
                     clr[i] = 1'b1;
            end
            `REG_DELAY:
               s_d.delay_ms = wdata[`DELAY_W-1:0];
            `REG_WEIGHT:
               if (wdata[31:7] == '0 && wdata[6:0] >= `WEIGHT_MIN && wdata[6:0] <= `WEIGHT_MAX)
                  s_d.weight[s_q.func] = wdata[6:0];
            `REG_FUNC:
               s_d.func = func_t'(wdata[2:0]);
            default:
            begin
            end
         endcase
      end

      // register reads, data stands one cycle later
      if (rd)
      begin
         case (addr)
            `REG_CTRL:
            begin
               s_d.rdata[`CTRL_FUNC_LSB +: 3]  = s_q.func;
               s_d.rdata[`CTRL_DIG_LSB +: 3]   = s_q.dig_req;
               s_d.rdata[`CTRL_RANGE_LSB +: 3] = s_q.range_sel;
               s_d.rdata[`CTRL_BUS_TRIG]       = s_q.bus_trig_en;
               s_d.rdata[`CTRL_EXT_TRIG]       = s_q.ext_trig_en;
               s_d.rdata[`CTRL_RQS]            = s_q.rqs_en;
               s_d.rdata[`CTRL_FILT]           = s_q.filt_en;
               s_d.rdata[`CTRL_EN_LSB +: `EN_W] = s_q.class_en;
            end
            `REG_DELAY:
               s_d.rdata[`DELAY_W-1:0] = s_q.delay_ms;
            `REG_WEIGHT:
               s_d.rdata[6:0] = w_cur;
            `REG_FUNC:
               s_d.rdata[2:0] = s_q.func;
            `REG_STATUS:
            begin
               s_d.rdata[`STAT_PEND_LSB +: `EV_N] = s_q.pend;
               s_d.rdata[`STAT_QV]                = s_q.queued_v;
               s_d.rdata[`STAT_SRQ]               = s_q.srq;
               s_d.rdata[`STAT_BUSY]              = (s_q.seq != SEQ_IDLE);
               s_d.rdata[`STAT_DISP_LSB +: 3]     = s_q.disp;
               s_d.rdata[`STAT_SENT_LSB +: 4]     = `SENT_DIGITS;
            end
            `REG_ERROR:
            begin
               if (s_q.rqs_en)
               begin
                  if (s_q.queued_v)
                     s_d.rdata[7:0] = s_q.queued;
                  s_d.queued_v = 1'b0;
               end
               else if (|s_q.pend)
               begin
                  s_d.rdata[7:0] = 8'(sel) + 8'h01;
                  clr[sel]       = 1'b1;
               end
            end
            `REG_POLL:
            begin
               if (s_q.rqs_en && |s_q.pend)
               begin
                  s_d.rdata[`STB_RQS_BIT] = 1'b1;
                  s_d.rdata[5:0]          = 6'(sel) + 6'h01;
                  s_d.queued              = 8'(sel) + 8'h01;
                  s_d.queued_v            = 1'b1;
                  clr[sel]                = 1'b1;
               end
               else
                  s_d.queued_v = 1'b0;
            end
            `REG_READING:
               s_d.rdata = {{(32-`DATA_W){s_q.avg[`DATA_W-1]}}, s_q.avg};
            default:
            begin
            end
         endcase
      end

      // trigger delay and conversion sequence
      case (s_q.seq)
         SEQ_IDLE:
            if (trig)
            begin
               s_d.seq     = SEQ_WAIT;
               s_d.ms_left = s_q.delay_ms;
               s_d.cyc     = '0;
            end
         SEQ_WAIT:
            if (s_q.ms_left == '0)
            begin
               s_d.conv_start = 1'b1;
               s_d.seq        = SEQ_CONV;
            end
            else if (s_q.cyc == CYC_LAST)
            begin
               s_d.cyc     = '0;
               s_d.ms_left = s_q.ms_left - `DELAY_W'(1);
            end
            else
               s_d.cyc = s_q.cyc + `CYC_W'(1);
         SEQ_CONV:
            if (conv.valid)
            begin
               s_d.seq       = SEQ_IDLE;
               s_d.avg_valid = 1'b1;
               if (s_q.filt_en && s_q.avg_valid)
                  s_d.avg = s_q.avg + step[`DATA_W-1:0];
               else
                  s_d.avg = conv.data;
               ev[`EV_DONE] = s_q.class_en[`EN_DONE];
               ev[`EV_OVER] = conv.ovf & s_q.class_en[`EN_OVER];
            end
         default:
            s_d.seq = SEQ_IDLE;
      endcase

      // event capture, gated by class enables
      ev[`EV_SYNTAX] = evt.syntax_err & s_q.class_en[`EN_ERR];
      ev[`EV_FULL]   = evt.buf_full & ~evt.buf_circular & s_q.class_en[`EN_FULL];
      ev[`EV_HALF]   = evt.buf_half & ~evt.buf_circular & s_q.class_en[`EN_HALF];
      ev[`EV_USER]   = evt.user_evt & s_q.class_en[`EN_USER];
      if (s_q.pon_todo && s_q.class_en[`EN_ERR])
      begin
         ev[`EV_PON]  = 1'b1;
         s_d.pon_todo = 1'b0;
      end

      // clears first, new events win; one entry per slot
      left     = s_q.pend & ~clr;
      s_d.pend = left | ev;
      if (s_q.first_v && clr[s_q.first_idx])
         s_d.first_v = 1'b0;
      if (!s_d.first_v && left == '0 && ev != '0)
      begin
         s_d.first_v = 1'b1;
         for (i = `EV_N - 1; i >= 0; i--)
            if (ev[i])
               s_d.first_idx = 3'(i);
      end

      s_d.srq  = s_q.rqs_en & |s_q.pend;
      s_d.disp = shown;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q             <= '0;
         s_q.func        <= dc_volts;
         s_q.dig_req     <= `DIG_MAX;
         s_q.class_en    <= `EN_W'(`CTRL_RST >> `CTRL_EN_LSB);
         s_q.weight      <= {8{`WEIGHT_RST}};
         s_q.seq         <= SEQ_IDLE;
         s_q.pon_todo    <= 1'b1;
         s_q.disp        <= `DIG_MAX;
      end
      else
         s_q <= s_d;
   end

   assign rdata       = s_q.rdata;
   assign conv_start  = s_q.conv_start;
   assign srq         = s_q.srq;
   assign disp_digits = s_q.disp;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_delay_zero: assert property ((s_q.seq == SEQ_IDLE && trig && s_q.delay_ms == '0) |-> ##2 conv_start)
      else $error("zero delay did not start conversion");
   chk_digit_cap: assert property ((s_q.func inside {ac_volts, dc_current, ac_current}) |=> disp_digits <= `DIG_CAP)
      else $error("displayed digits above cap");
   chk_digit_query: assert property ((rd && addr == `REG_CTRL) |=> rdata[`CTRL_DIG_LSB +: 3] == $past(s_q.dig_req))
      else $error("digit query not the request");
   chk_bus_trigger: assert property ((s_q.seq == SEQ_IDLE && get_msg && s_q.bus_trig_en) |=> s_q.seq == SEQ_WAIT)
      else $error("bus trigger not taken");
   chk_error_gated: assert property ((rd && addr == `REG_ERROR && s_q.rqs_en && !s_q.queued_v) |=> rdata == '0)
      else $error("error given before poll");
   chk_error_once: assert property ((rd && addr == `REG_ERROR && s_q.rqs_en) |=> !s_q.queued_v ##1 !s_q.queued_v || $past(rd))
      else $error("queued code kept after query");
   chk_second_poll: assert property ((rd && addr == `REG_POLL && s_q.queued_v && s_q.pend == '0) |=> !s_q.queued_v)
      else $error("second poll kept queued code");
   chk_srq_gate: assert property (!s_q.rqs_en |=> !srq)
      else $error("service request without enable");
   chk_syntax_drop: assert property ((!s_q.class_en[`EN_ERR] && !s_q.pend[`EV_SYNTAX]) |=> !s_q.pend[`EV_SYNTAX])
      else $error("syntax error queued while disabled");
   chk_weight_range: assert property (w_cur >= `WEIGHT_MIN && w_cur <= `WEIGHT_MAX)
      else $error("filter weight out of range");
   chk_wrap_full: assert property ((evt.buf_circular && !s_q.pend[`EV_FULL]) |=> !s_q.pend[`EV_FULL])
      else $error("wrap raised full event");
   chk_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   chk_srq_raise: assert property ((s_q.rqs_en && |s_q.pend) |=> srq)
      else $error("service request not raised");

   cov_conversion: cover property (s_q.seq == SEQ_WAIT ##1 conv_start);
   cov_srq_poll: cover property (srq ##1 (rd && addr == `REG_POLL) ##1 rd && addr == `REG_ERROR);
   cov_filtered: cover property (s_q.seq == SEQ_CONV && conv.valid && s_q.filt_en && s_q.avg_valid);
   cov_ext_trigger: cover property (s_q.seq == SEQ_IDLE && s_q.ext_trig_en && ext_s && !s_q.ext_prev);
endmodule
`default_nettype wire

// ### dv/conv_model.sv
// converter model answering each conversion start after a fixed latency
`timescale 1ns/1ps
`default_nettype none
module conv_model import meter_pkg::*; #(
   parameter int LAT = 3
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // converter side
   input  wire logic        start,
   input  wire logic [23:0] value,
   output var  conv_t       conv
);
   int cnt;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt  <= 0;
         conv <= '0;
      end
      else
      begin
         conv.valid <= (cnt == 1);
         conv.ovf   <= 1'b0;
         // data outside the valid cycle is scrambled
         conv.data  <= (cnt == 1) ? value : ~conv.data;
         if (start)
            cnt <= LAT;
         else if (cnt != 0)
            cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// ### dv/meter_ctrl_tb.sv
// self-checking bench for the meter settings and event logic
`timescale 1ns/1ps
`default_nettype none
module meter_ctrl_tb;
   import meter_pkg::*;
   localparam int CPM = 4;
   localparam logic [31:0] E  = 32'h0020_0000;
   localparam logic [31:0] BT = 32'h0000_1000;
   localparam logic [31:0] XT = 32'h0000_2000;
   localparam logic [31:0] RQ = 32'h0000_4000;
   localparam logic [31:0] FL = 32'h0000_8000;
   localparam logic [31:0] FU = 32'h0002_0000;
   localparam logic [31:0] US = 32'h0008_0000;
   logic        clk;
   logic        rst_n;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        get_msg;
   logic        ext_trig;
   logic        conv_start;
   conv_t       conv;
   evt_t        evt;
   logic        srq;
   logic [2:0]  disp_digits;
   logic [23:0] conv_val;
   logic        use_ext;
   int          err_count;
   int          compares;
   int          cyc;
   int          n;
   logic [2:0]  e6 [8] = '{3'h6, 3'h5, 3'h6, 3'h5, 3'h5, 3'h5, 3'h5, 3'h6};
   logic [2:0]  e3 [8] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h5, 3'h5, 3'h5};

   meter_ctrl #(.CYCLES_PER_MS(CPM)) i_meter_ctrl (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .get_msg(get_msg), .ext_trig(ext_trig), .conv_start(conv_start), .conv(conv), .evt(evt),
      .srq(srq), .disp_digits(disp_digits));

   conv_model i_conv_model (.clk(clk), .rst_n(rst_n), .start(conv_start), .value(conv_val), .conv(conv));

   always #50 clk = ~clk;

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         close_out();
      end
   end

   task close_out();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: %s got %0h expected %0h", $time, m, got, exp);
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string m);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(rdata & mask, exp, m);
   endtask

   task pulse(input evt_t e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // n counts cycles from the trigger cycle to the start pulse, 40 if none
   task trig();
      @(posedge clk);
      get_msg  <= ~use_ext;
      ext_trig <= use_ext;
      @(posedge clk);
      get_msg  <= 1'b0;
      ext_trig <= 1'b0;
      n = 1;
      #1;
      while (conv_start !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      repeat (6) @(posedge clk);
   endtask

   function automatic logic [31:0] mk(input logic [2:0] f, input logic [2:0] d, input logic [2:0] r,
                                      input logic [31:0] hi);
      return hi | (32'(r) << 8) | (32'(d) << 4) | 32'(f);
   endfunction

   task ev(input logic s, input logic u, input logic f, input logic c);
      evt_t e;
      e = '{syntax_err: s, user_evt: u, buf_full: f, buf_half: 1'b0, buf_circular: c};
      pulse(e);
   endtask

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {addr, wdata, wr, rd, get_msg, ext_trig, evt, conv_val, use_ext} = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk(32'(disp_digits), 32'h6, "reset digits");
      rd_chk(8'h14, 32'hFF, 32'h1, "power-on event");
      rd_chk(8'h14, 32'hFF, 32'h0, "power-on once");
      rd_chk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped read");
      rd_chk(8'h10, 32'h000F0000, 32'h00070000, "sent digits");
      $display("test reset done");

      for (int f = 0; f < 8; f++)
      begin
         wr_reg(8'h00, mk(3'(f), 3'h6, 3'h0, E));
         repeat (2) @(posedge clk);
         #1;
         chk(32'(disp_digits), 32'(e6[f]), "digits for 6");
         wr_reg(8'h00, mk(3'(f), 3'h3, 3'h0, E));
         repeat (2) @(posedge clk);
         #1;
         chk(32'(disp_digits), 32'(e3[f]), "digits for 3");
      end
      wr_reg(8'h00, mk(3'h2, 3'h6, 3'h5, E));
      repeat (2) @(posedge clk);
      #1;
      chk(32'(disp_digits), 32'h5, "high ohm range");
      wr_reg(8'h00, mk(3'h3, 3'h6, 3'h0, E));
      rd_chk(8'h00, 32'h70, 32'h60, "digit query");
      wr_reg(8'h0C, 32'h0);
      repeat (2) @(posedge clk);
      #1;
      chk(32'(disp_digits), 32'h6, "recomputed digits");
      $display("test digits done");

      wr_reg(8'h04, 32'h2);
      rd_chk(8'h04, 32'hFFFF, 32'h2, "delay query");
      trig();
      chk(32'(n), 32'd40, "bus trigger off");
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | BT));
      trig();
      chk(32'(n), 32'(2 + 2 * CPM), "delay to start");
      wr_reg(8'h04, 32'h0);
      trig();
      chk(32'(n), 32'h2, "zero delay");
      use_ext = 1'b1;
      trig();
      chk(32'(n), 32'd40, "external trigger off");
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | BT | XT));
      trig();
      // two synchroniser stages, edge detect, then zero delay
      chk(32'(n), 32'h4, "external trigger");
      use_ext = 1'b0;
      $display("test trigger done");

      wr_reg(8'h08, 32'd100);
      rd_chk(8'h08, 32'h7F, 32'h1, "weight refused");
      wr_reg(8'h08, 32'd4);
      rd_chk(8'h08, 32'h7F, 32'h4, "weight dc");
      wr_reg(8'h0C, 32'h1);
      rd_chk(8'h08, 32'h7F, 32'h1, "weight ac");
      wr_reg(8'h0C, 32'h0);
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | BT | FL));
      conv_val <= 24'h0;
      trig();
      conv_val <= 24'd100;
      trig();
      rd_chk(8'h1C, 32'hFFFFFFFF, 32'd25, "filtered");
      wr_reg(8'h0C, 32'h1);
      wr_reg(8'h08, 32'd3);
      conv_val <= 24'd40;
      trig();
      // 25 plus (40 - 25) / 3 with the ac weight
      rd_chk(8'h1C, 32'hFFFFFFFF, 32'd30, "global filter");
      $display("test filter done");

      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | RQ));
      ev(1'b1, 1'b0, 1'b0, 1'b0);
      chk(32'(srq), 32'h1, "service request");
      rd_chk(8'h14, 32'hFF, 32'h0, "before poll");
      rd_chk(8'h18, 32'hFF, 32'h42, "poll byte");
      rd_chk(8'h14, 32'hFF, 32'h2, "after poll");
      rd_chk(8'h14, 32'hFF, 32'h0, "only once");
      ev(1'b1, 1'b0, 1'b0, 1'b0);
      rd_chk(8'h18, 32'hFF, 32'h42, "first poll");
      rd_chk(8'h18, 32'hFF, 32'h0, "second poll");
      rd_chk(8'h14, 32'hFF, 32'h0, "code discarded");
      ev(1'b1, 1'b0, 1'b0, 1'b0);
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E));
      repeat (2) @(posedge clk);
      #1;
      chk(32'(srq), 32'h0, "request gated");
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | RQ));
      repeat (2) @(posedge clk);
      #1;
      chk(32'(srq), 32'h1, "error kept");
      rd_chk(8'h18, 32'hFF, 32'h42, "kept poll");
      rd_chk(8'h14, 32'hFF, 32'h2, "kept code");
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | RQ | FU));
      ev(1'b0, 1'b0, 1'b1, 1'b1);
      chk(32'(srq), 32'h0, "wrap no event");
      ev(1'b0, 1'b0, 1'b1, 1'b0);
      chk(32'(srq), 32'h1, "full request");
      rd_chk(8'h18, 32'hFF, 32'h44, "full poll");
      rd_chk(8'h14, 32'hFF, 32'h4, "full code");
      $display("test service request done");

      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | US | FU));
      ev(1'b0, 1'b1, 1'b0, 1'b0);
      ev(1'b1, 1'b0, 1'b0, 1'b0);
      ev(1'b0, 1'b0, 1'b1, 1'b0);
      rd_chk(8'h14, 32'hFF, 32'h6, "earliest");
      rd_chk(8'h14, 32'hFF, 32'h2, "highest");
      rd_chk(8'h14, 32'hFF, 32'h4, "full queued");
      rd_chk(8'h14, 32'hFF, 32'h0, "empty");
      ev(1'b0, 1'b1, 1'b0, 1'b0);
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | FU));
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, E | US | FU));
      rd_chk(8'h14, 32'hFF, 32'h0, "class dropped");
      wr_reg(8'h00, mk(3'h0, 3'h6, 3'h0, 32'h0));
      ev(1'b1, 1'b0, 1'b0, 1'b0);
      rd_chk(8'h14, 32'hFF, 32'h0, "silent syntax");
      $display("test queue done");
      close_out();
   end
endmodule
`default_nettype wire
